/* src/nvs_pkg.sv */
// Shared constants, types and helpers for the nonvolatile SRAM host controller.
// Assumes a single 10 MHz clock and a device that follows the pin protocol below.
package nvs_pkg;

  // ---------------------------------------------------------------------------
  // Widths and software sequence addresses
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int SEQ_LEN = 6;
  localparam logic [2:0] SEQ_LAST = 3'h5;
  localparam logic [10:0] SEQ_A0 = 11'h000;
  localparam logic [10:0] SEQ_A1 = 11'h555;
  localparam logic [10:0] SEQ_A2 = 11'h2aa;
  localparam logic [10:0] SEQ_A3 = 11'h7ff;
  localparam logic [10:0] SEQ_A4 = 11'h0f0;
  localparam logic [10:0] SEQ_STORE = 11'h70f;
  localparam logic [10:0] SEQ_RECALL = 11'h70e;
  localparam logic [10:0] SEQ_RESERVED = 11'h39c;

  // ---------------------------------------------------------------------------
  // Times and cycle counts
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int STORE_TIME_MS = 10;
  localparam int RECALL_TIME_US = 20;
  localparam int RESTORE_TIME_US = 650;
  localparam int INIT_TIME_NS = 25;
  localparam int ACCESS_TIME_NS = 35;
  // The host must wait out the device maximum, so every count rounds up.
  localparam int STORE_CYC = (STORE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECALL_CYC = (RECALL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTORE_CYC = (RESTORE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CYC = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 17;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_SW_STORE = 3'h2,
    OP_SW_RECALL = 3'h3,
    OP_HW_STORE = 3'h4,
    OP_HW_RECALL = 3'h5
  } nvs_op_e;

  // Gray codes along boot, idle, setup, strobe, hold, wait.
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_IDLE = 3'h1,
    ST_SETUP = 3'h3,
    ST_STROBE = 3'h2,
    ST_HOLD = 3'h6,
    ST_WAIT = 3'h7
  } nvs_state_e;

  typedef struct packed {
    nvs_op_e op;
    logic [10:0] addr;
    logic [7:0] data;
  } nvs_cmd_s;

  typedef struct packed {
    logic chip_sel_n;
    logic out_en_n;
    logic wr_en_n;
    logic nonvolatile_select_n;
    logic [10:0] byte_location_inputs;
  } nvs_pins_s;

  localparam nvs_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 11'h000};

  // Address of step idx of a software sequence; the last step picks the transfer.
  function automatic logic [10:0] seq_addr(input logic [2:0] idx, input logic recall);
    logic [10:0] a;
    a = SEQ_A0;
    case (idx)
      3'h1: a = SEQ_A1;
      3'h2: a = SEQ_A2;
      3'h3: a = SEQ_A3;
      3'h4: a = SEQ_A4;
      3'h5: a = recall ? SEQ_RECALL : SEQ_STORE;
      default: a = SEQ_A0;
    endcase
    return a;
  endfunction

endpackage

/* src/nvs_wait_timer.sv */
// Loadable down-counter that times strobes, device busy periods and power-up.
// Assumes the caller loads it only when it wants a fresh interval.
`timescale 1ns/100ps
module nvs_wait_timer #(
  parameter int W = 17,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk, // Clock.
  input wire logic rst_n, // Synchronised active-low reset.
  input wire logic clk_en, // Freezes the count while low.
  input wire logic load, // Starts a new interval.
  input wire logic [W-1:0] load_val, // Cycles left after the load edge.
  output logic expired // High while the count is zero.
);

  logic [W-1:0] count_r;

  // Load wins over counting; the count stops at zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= RESET_VAL;
    end else if (clk_en) begin
      if (load) begin
        count_r <= load_val;
      end else if (count_r != '0) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  assign expired = (count_r == '0);

endmodule

/* src/nvs_host_ctrl.sv */
// Host controller for a 2K x 8 SRAM with nonvolatile shadow cells.
// Assumes the device pins are sampled on ref_clk and pad logic resolves the data bus.
`timescale 1ns/100ps
module nvs_host_ctrl #(
  parameter int STORE_CYCLES = nvs_pkg::STORE_CYC, // Store busy wait.
  parameter int RESTORE_CYCLES = nvs_pkg::RESTORE_CYC // Power-up wait.
) (
  input wire logic ref_clk, // 10 MHz clock.
  input wire logic rst_n, // Asynchronous active-low reset.
  input wire logic clk_en, // Freezes all state but the reset synchroniser while low.
  input wire logic cmd_valid, // Command offered.
  output logic cmd_ready, // Command taken when both high.
  input wire nvs_pkg::nvs_cmd_s cmd, // Operation, address and write data.
  output logic rsp_valid, // One-cycle pulse when a command finishes.
  output logic [7:0] rsp_data, // Byte from the last read.
  output nvs_pkg::nvs_pins_s pins, // Control and address pins of the device.
  input wire logic [7:0] bus_in, // Level seen on the byte bus.
  output logic [7:0] bus_out, // Byte driven onto the bus.
  output logic bus_oe // High while the host drives the bus.
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_sync_n;

  // Two flops so the release is synchronous to ref_clk.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_sync_r[1];

  // ---------------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------------
  nvs_pkg::nvs_state_e state_r, state_nxt;
  nvs_pkg::nvs_cmd_s cmd_r;
  nvs_pkg::nvs_pins_s pins_r, pins_nxt;
  logic [2:0] idx_r;
  logic [7:0] rsp_data_r, bus_out_r;
  logic rsp_valid_r, bus_oe_r;
  logic tmr_load, tmr_exp;
  logic [nvs_pkg::TMR_W-1:0] tmr_val;
  logic is_seq, is_last, is_write, is_read, long_wait, accept;
  logic [10:0] addr_sel;
  nvs_pkg::nvs_cmd_s cmd_nx;
  logic [2:0] idx_nx;
  logic step_adv;

  localparam logic [nvs_pkg::TMR_W-1:0] INIT_LEN = nvs_pkg::TMR_W'(nvs_pkg::INIT_CYC - 1);
  localparam logic [nvs_pkg::TMR_W-1:0] ACC_LEN = nvs_pkg::TMR_W'(nvs_pkg::ACCESS_CYC - 1);
  localparam logic [nvs_pkg::TMR_W-1:0] STORE_LEN = nvs_pkg::TMR_W'(STORE_CYCLES - 1);
  localparam logic [nvs_pkg::TMR_W-1:0] RECALL_LEN = nvs_pkg::TMR_W'(nvs_pkg::RECALL_CYC - 1);
  localparam logic [nvs_pkg::TMR_W-1:0] RESTORE_LEN = nvs_pkg::TMR_W'(RESTORE_CYCLES - 1);

  // Command decode; the sequence flags steer the address and the end of a step.
  assign accept = cmd_valid && cmd_ready;
  assign is_seq = (cmd_r.op == nvs_pkg::OP_SW_STORE) || (cmd_r.op == nvs_pkg::OP_SW_RECALL);
  assign is_last = (idx_r == nvs_pkg::SEQ_LAST);
  assign is_write = (cmd_r.op == nvs_pkg::OP_WRITE);
  assign is_read = (cmd_r.op == nvs_pkg::OP_READ);
  assign long_wait = !is_write && !is_read;
  // A step's pins are decoded from the command and step that take effect at the same edge.
  // Decoding from the latched copy would put out the previous command's address for one step.
  assign step_adv = (state_r == nvs_pkg::ST_HOLD) && is_seq && !is_last;
  assign cmd_nx = accept ? cmd : cmd_r;
  assign idx_nx = accept ? 3'h0 : (step_adv ? idx_r + 3'h1 : idx_r);
  assign addr_sel = (cmd_nx.op == nvs_pkg::OP_SW_STORE || cmd_nx.op == nvs_pkg::OP_SW_RECALL) ?
                    nvs_pkg::seq_addr(idx_nx, cmd_nx.op == nvs_pkg::OP_SW_RECALL) : cmd_nx.addr;
  // Only idle accepts, so nothing can slip between the six reads.
  assign cmd_ready = (state_r == nvs_pkg::ST_IDLE);

  // Next state and timer loads.
  always_comb begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_r)
      nvs_pkg::ST_BOOT: begin
        if (tmr_exp) state_nxt = nvs_pkg::ST_IDLE;
      end
      nvs_pkg::ST_IDLE: begin
        if (cmd_valid) state_nxt = nvs_pkg::ST_SETUP;
      end
      nvs_pkg::ST_SETUP: begin
        state_nxt = nvs_pkg::ST_STROBE;
        tmr_load = 1'b1;
        // Hardware cycles hold the trigger for the initiation time, accesses for access time.
        tmr_val = (cmd_r.op == nvs_pkg::OP_HW_STORE || cmd_r.op == nvs_pkg::OP_HW_RECALL) ? INIT_LEN : ACC_LEN;
      end
      nvs_pkg::ST_STROBE: begin
        if (tmr_exp) state_nxt = nvs_pkg::ST_HOLD;
      end
      nvs_pkg::ST_HOLD: begin
        if (is_seq && !is_last) begin
          state_nxt = nvs_pkg::ST_SETUP;
        end else if (long_wait) begin
          state_nxt = nvs_pkg::ST_WAIT;
          tmr_load = 1'b1;
          // Device ignores all pins while busy, so the host simply waits it out.
          tmr_val = (cmd_r.op == nvs_pkg::OP_SW_STORE || cmd_r.op == nvs_pkg::OP_HW_STORE) ? STORE_LEN : RECALL_LEN;
        end else begin
          state_nxt = nvs_pkg::ST_IDLE;
        end
      end
      nvs_pkg::ST_WAIT: begin
        if (tmr_exp) state_nxt = nvs_pkg::ST_IDLE;
      end
      default: state_nxt = nvs_pkg::ST_IDLE;
    endcase
  end

  // Pin levels for the coming cycle; every control pin returns high outside setup and strobe.
  // Hardware store: select and nonvolatile low first, write falls last so no SRAM write happens.
  // Hardware recall: output enable and nonvolatile low first, select falls last, write held high.
  // Software sequence reads keep output enable high; detection does not depend on it.
  assign pins_nxt.chip_sel_n = !((state_nxt == nvs_pkg::ST_STROBE) ||
                                 (state_nxt == nvs_pkg::ST_SETUP && cmd_nx.op == nvs_pkg::OP_HW_STORE));
  assign pins_nxt.out_en_n = !((state_nxt == nvs_pkg::ST_STROBE && is_read) ||
                               ((state_nxt == nvs_pkg::ST_SETUP || state_nxt == nvs_pkg::ST_STROBE) &&
                                cmd_nx.op == nvs_pkg::OP_HW_RECALL));
  assign pins_nxt.wr_en_n = !(state_nxt == nvs_pkg::ST_STROBE &&
                              (is_write || cmd_r.op == nvs_pkg::OP_HW_STORE));
  assign pins_nxt.nonvolatile_select_n = !((state_nxt == nvs_pkg::ST_SETUP || state_nxt == nvs_pkg::ST_STROBE) &&
                                           (cmd_nx.op == nvs_pkg::OP_HW_STORE ||
                                            cmd_nx.op == nvs_pkg::OP_HW_RECALL));
  // The address changes only when a new step begins, so it is stable through the write.
  assign pins_nxt.byte_location_inputs = (state_nxt == nvs_pkg::ST_SETUP) ? addr_sel
                                         : pins_r.byte_location_inputs;

  // State, pin and timer-independent registers.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= nvs_pkg::ST_BOOT;
      pins_r <= nvs_pkg::PINS_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
      pins_r <= pins_nxt;
    end
  end

  // Command latch and sequence step; the step restarts with every accepted command.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmd_r <= '{nvs_pkg::OP_READ, 11'h000, 8'h00};
      idx_r <= 3'h0;
    end else if (clk_en) begin
      cmd_r <= cmd_nx;
      idx_r <= idx_nx;
    end
  end

  // Data bus: write data is driven through strobe and hold, read data is caught at strobe end.
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_out_r <= 8'h00;
      bus_oe_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_valid_r <= 1'b0;
    end else if (clk_en) begin
      bus_out_r <= cmd_r.data;
      bus_oe_r <= is_write && (state_nxt == nvs_pkg::ST_STROBE || state_nxt == nvs_pkg::ST_HOLD);
      if (state_r == nvs_pkg::ST_STROBE && tmr_exp && is_read) rsp_data_r <= bus_in;
      rsp_valid_r <= (state_nxt == nvs_pkg::ST_IDLE) &&
                     (state_r == nvs_pkg::ST_HOLD || state_r == nvs_pkg::ST_WAIT);
    end
  end

  nvs_wait_timer #(
    .W(nvs_pkg::TMR_W),
    .RESET_VAL(RESTORE_LEN)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .clk_en(clk_en),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_exp)
  );

  assign pins = pins_r;
  assign bus_out = bus_out_r;
  assign bus_oe = bus_oe_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic seq_strobe;
  assign seq_strobe = is_seq && !pins_r.chip_sel_n;

  a_seq_write_high: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    seq_strobe |-> pins_r.wr_en_n && pins_r.nonvolatile_select_n)
    else $error("Write or nonvolatile select low inside a software sequence.");
  a_seq_first_addr: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    seq_strobe && idx_r == 3'h0 |-> pins_r.byte_location_inputs == nvs_pkg::SEQ_A0)
    else $error("Software sequence does not open at address zero.");
  a_seq_store_end: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    seq_strobe && is_last && cmd_r.op == nvs_pkg::OP_SW_STORE |-> pins_r.byte_location_inputs == nvs_pkg::SEQ_STORE)
    else $error("Store sequence ends at the wrong address.");
  a_seq_recall_end: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    seq_strobe && is_last && cmd_r.op == nvs_pkg::OP_SW_RECALL |-> pins_r.byte_location_inputs == nvs_pkg::SEQ_RECALL)
    else $error("Recall sequence ends at the wrong address.");
  a_seq_no_reserved: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    seq_strobe |-> pins_r.byte_location_inputs != nvs_pkg::SEQ_RESERVED)
    else $error("Reserved test address issued in a sequence.");
  a_seq_one_pulse: assert property (@(posedge ref_clk) disable iff (!rst_sync_n || !clk_en)
    $fell(pins_r.chip_sel_n) && is_seq |=> pins_r.chip_sel_n ##1 pins_r.chip_sel_n)
    else $error("Sequence select pulse is not a single cycle.");
  a_seq_atomic: assert property (@(posedge ref_clk) disable iff (!rst_sync_n || !clk_en)
    is_seq && state_r == nvs_pkg::ST_HOLD && !is_last |=> state_r == nvs_pkg::ST_SETUP && !cmd_ready)
    else $error("Command accepted in the middle of a sequence.");
  a_write_addr_hold: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    $rose(pins_r.wr_en_n) && is_write |-> $stable(pins_r.byte_location_inputs))
    else $error("Address moved at the end of a write.");
  a_write_oe_high: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    !pins_r.wr_en_n || bus_oe_r |-> pins_r.out_en_n)
    else $error("Output enable low while writing.");

  c_sw_store: cover property (@(posedge ref_clk) seq_strobe && pins_r.byte_location_inputs == nvs_pkg::SEQ_STORE);
  c_sw_recall: cover property (@(posedge ref_clk) seq_strobe && pins_r.byte_location_inputs == nvs_pkg::SEQ_RECALL);
  c_hw_store: cover property (@(posedge ref_clk) !pins_r.wr_en_n && !pins_r.nonvolatile_select_n);
  c_write_done: cover property (@(posedge ref_clk) rsp_valid_r && is_write);

endmodule

/* verification/nvs_dev_model.sv */
// Behavioural model of the nonvolatile SRAM as seen at its pins.
// Assumes host pins change on ref_clk edges; busy times are shortened.
`timescale 1ns/100ps
module nvs_dev_model #(
  parameter int STORE_NS = 1500, // Shortened store busy time.
  parameter int RECALL_NS = 10000, // Recall busy time.
  parameter int POWERUP_NS = 300 // Shortened power-up restore time.
) (
  input wire logic ref_clk, // Only paces the idle bus pattern.
  input wire nvs_pkg::nvs_pins_s pins, // Control and address pins.
  input wire logic [7:0] host_dq, // Byte the host drives.
  input wire logic host_oe, // High while the host drives.
  output logic [7:0] bus_level // Resolved level of the byte bus.
);
  // ---------------------------------------------------------------------------
  // Storage and decode
  // ---------------------------------------------------------------------------
  logic [7:0] mem [2048];
  logic [7:0] nv [2048];
  logic busy;
  logic [7:0] idle_r;
  logic hs_q;
  logic hr_q;
  int idx;
  wire hs = !pins.chip_sel_n && !pins.wr_en_n && pins.out_en_n && !pins.nonvolatile_select_n;
  wire hr = !pins.chip_sel_n && !pins.out_en_n && pins.wr_en_n && !pins.nonvolatile_select_n;
  wire wr_act = !busy && !pins.chip_sel_n && !pins.wr_en_n && pins.nonvolatile_select_n;
  wire rd_act = !busy && !pins.chip_sel_n && !pins.out_en_n && pins.wr_en_n && pins.nonvolatile_select_n;

  // A released bus shows a changing pattern, never the last value.
  assign bus_level = host_oe ? host_dq : rd_act ? mem[pins.byte_location_inputs] : idle_r;

  // The whole transfer is one copy; inputs are ignored until busy drops.
  task automatic run_nv(input bit st);
    busy = 1'b1;
    idx = 0;
    if (st) nv = mem; else mem = nv;
    #(st ? STORE_NS : RECALL_NS);
    busy = 1'b0;
  endtask

  // Power-up restore keeps the part busy before any access.
  initial begin
    foreach (nv[i]) nv[i] = 8'h00;
    idle_r = 8'h5a;
    hs_q = 1'b0;
    hr_q = 1'b0;
    idx = 0;
    busy = 1'b1;
    mem = nv;
    #(POWERUP_NS);
    busy = 1'b0;
  end

  always @(posedge ref_clk) idle_r <= ~idle_r;

  // Only a fresh entry into the store or recall state starts a cycle.
  always @(hs or hr) begin : hw_ctl
    logic go_s;
    logic go_r;
    go_s = hs && !hs_q && !busy;
    go_r = hr && !hr_q && !busy;
    hs_q = hs;
    hr_q = hr;
    if (go_s || go_r) begin
      run_nv(go_s);
      hs_q = hs;
      hr_q = hr;
    end
  end

  // Each select strobe with write enable high is one sequence read, whatever read enable does; write low resets it.
  always @(negedge pins.chip_sel_n) if (!busy && pins.nonvolatile_select_n) begin
    if (!pins.wr_en_n) idx = 0;
    else if (idx == 5 && pins.byte_location_inputs[10:1] == 10'h387) run_nv(pins.byte_location_inputs[0]);
    else if (idx < 5 && pins.byte_location_inputs == step_addr(idx)) idx = idx + 1;
    else idx = (pins.byte_location_inputs == 11'h000) ? 1 : 0;
  end

  // The byte is taken as the write state ends, with the address still held.
  always @(negedge wr_act) mem[pins.byte_location_inputs] = bus_level;

  function automatic logic [10:0] step_addr(input int i);
    case (i)
      0: return 11'h000;
      1: return 11'h555;
      2: return 11'h2aa;
      3: return 11'h7ff;
      default: return 11'h0f0;
    endcase
  endfunction
endmodule

/* verification/nvs_host_ctrl_tb_top.sv */
// Self-checking bench for the nonvolatile SRAM host controller.
// Assumes the behavioural device model and shortened store and restore counts.
`timescale 1ns/100ps
module nvs_host_ctrl_tb_top;
  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic ref_clk;
  logic rst_n;
  logic clk_en;
  logic cmd_valid;
  logic cmd_ready;
  nvs_pkg::nvs_cmd_s cmd;
  logic rsp_valid;
  logic [7:0] rsp_data;
  nvs_pkg::nvs_pins_s pins;
  logic [7:0] bus_level;
  logic [7:0] bus_out;
  logic bus_oe;
  int fail_count;
  int compares;
  logic [10:0] cs_addr[$];
  logic cs_we[$];

  nvs_host_ctrl #(.STORE_CYCLES(20), .RESTORE_CYCLES(5)) nvs_host_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .bus_in(bus_level),
    .bus_out(bus_out), .bus_oe(bus_oe));
  nvs_dev_model nvs_dev_model_inst (
    .ref_clk(ref_clk), .pins(pins), .host_dq(bus_out), .host_oe(bus_oe), .bus_level(bus_level));

  // Clock at 10 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Log every select strobe so the sequence order can be judged later.
  always @(negedge pins.chip_sel_n) begin
    cs_addr.push_back(pins.byte_location_inputs);
    cs_we.push_back(pins.wr_en_n);
  end

  // Driving the bus while read enable is low would cause contention.
  always @(negedge ref_clk) if (rst_n === 1'b1 && bus_oe === 1'b1) chk(16'(pins.out_en_n), 16'h0001, "contention");

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Offer one command, wait for it to be taken and for its completion pulse.
  task automatic do_cmd(input nvs_pkg::nvs_op_e op, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, a, d};
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(cmd_ready), 16'h0001, "never ready");
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(negedge ref_clk);
    chk(16'(cmd_ready), 16'h0000, "busy host took work");
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(rsp_valid), 16'h0001, "no completion");
  endtask

  // Back-to-back writes then reads at both ends of the address range.
  task automatic test_rw();
    logic [10:0] al [3];
    al = '{11'h000, 11'h7ff, 11'h555};
    foreach (al[i]) do_cmd(nvs_pkg::OP_WRITE, al[i], 8'h3c ^ al[i][7:0]);
    foreach (al[i]) begin
      do_cmd(nvs_pkg::OP_READ, al[i], 8'h00);
      chk(16'(rsp_data), 16'(8'h3c ^ al[i][7:0]), "read back");
    end
    $display("test_rw done");
  endtask

  // Software store, overwrite, software recall brings the stored byte back.
  task automatic test_sw();
    logic [10:0] exp_a [6];
    exp_a = '{11'h000, 11'h555, 11'h2aa, 11'h7ff, 11'h0f0, 11'h70f};
    do_cmd(nvs_pkg::OP_WRITE, 11'h123, 8'h11);
    cs_addr.delete();
    cs_we.delete();
    do_cmd(nvs_pkg::OP_SW_STORE, 11'h000, 8'h00);
    chk(16'(cs_addr.size()), 16'h0006, "strobe count");
    foreach (exp_a[i]) begin
      chk(16'(cs_addr[i]), 16'(exp_a[i]), "sequence address");
      chk(16'(cs_we[i]), 16'h0001, "write in sequence");
    end
    do_cmd(nvs_pkg::OP_WRITE, 11'h123, 8'h22);
    cs_addr.delete();
    do_cmd(nvs_pkg::OP_SW_RECALL, 11'h000, 8'h00);
    chk(16'(cs_addr[5]), 16'h070e, "recall last address");
    do_cmd(nvs_pkg::OP_READ, 11'h123, 8'h00);
    chk(16'(rsp_data), 16'h0011, "recalled byte");
    $display("test_sw done");
  endtask

  // Pin-initiated store and recall, then a plain read proves no retrigger.
  task automatic test_hw();
    do_cmd(nvs_pkg::OP_WRITE, 11'h200, 8'h77);
    do_cmd(nvs_pkg::OP_HW_STORE, 11'h000, 8'h00);
    do_cmd(nvs_pkg::OP_WRITE, 11'h200, 8'h00);
    do_cmd(nvs_pkg::OP_READ, 11'h200, 8'h00);
    chk(16'(rsp_data), 16'h0000, "overwrite");
    do_cmd(nvs_pkg::OP_HW_RECALL, 11'h000, 8'h00);
    do_cmd(nvs_pkg::OP_READ, 11'h200, 8'h00);
    chk(16'(rsp_data), 16'h0077, "hardware recalled byte");
    $display("test_hw done");
  endtask

  task automatic finish_test();
    $display("Counts: compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The tests need under a thousand cycles; five thousand means a hang.
  initial begin
    #(5000 * 100);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    fail_count = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_rw();
    test_sw();
    test_hw();
    finish_test();
  end
endmodule
